// >>> hdl/acq_arm_defs.svh
// Offsets, field positions, reset values and timing counts of the arm controller
`ifndef ACQ_ARM_DEFS_SVH
`define ACQ_ARM_DEFS_SVH
// ------------------------------------------------------------
// Register byte offsets
// ------------------------------------------------------------
`define ARM_CTRL_OFS 12'h000
`define ARM_DELAY_OFS 12'h004
`define ARM_SCALE_OFS 12'h008
`define ARM_SEQ_OFS 12'h00C
`define ARM_STAT_OFS 12'h010
`define ARM_CMD_OFS 12'h014
// ------------------------------------------------------------
// Control field positions
// ------------------------------------------------------------
`define CTRL_POLICY_LSB 0
`define CTRL_STYLE_LSB 2
`define CTRL_WRAP_BIT 4
`define CTRL_RECLEN_LSB 8
`define CMD_ARM_BIT 0
`define CMD_HALT_BIT 1
`define CMD_ZERO_BIT 2
`define CMD_SCUP_BIT 3
`define CMD_SCDN_BIT 4
`define DELAY_POST_BIT 31
// ------------------------------------------------------------
// Reset values and limits
// ------------------------------------------------------------
`define CTRL_RESET 32'h0000_0000
`define SCALE_RESET 5'd9
`define SCALE_MAX 5'd26
`define RECLEN_MAX 3'd4
`define PRE_MAX_PCT 7'd100
`define POST_MAX_TENTHS 17'd100000
`define INTERLEAVE_MAX 12'd4000
`define SEQ_TMO_RESET 32'h017D_7840
// ------------------------------------------------------------
// Times and derived cycle counts at 25 MHz
// ------------------------------------------------------------
`define CLK_HZ 25000000
`define FREE_TMO_MS 500
`define FREE_TMO_CYC ((`CLK_HZ / 1000) * `FREE_TMO_MS)
`define INTERLEAVE_TMO_MS 1000
`define INTERLEAVE_TMO_CYC ((`CLK_HZ / 1000) * `INTERLEAVE_TMO_MS)
`define PAUSE_MS 200
`define PAUSE_CYC ((`CLK_HZ / 1000) * `PAUSE_MS)
`endif

// >>> hdl/acq_arm_pkg.sv
// Types of the acquisition arm controller
package acq_arm_pkg;
  typedef enum logic [1:0] {
    POL_FREE = 2'b00,
    POL_REPEAT = 2'b01,
    POL_SINGLE = 2'b10
  } policy_t;
  typedef enum logic [1:0] {
    STY_SHOT = 2'b00,
    STY_INTERLEAVED = 2'b01,
    STY_SCROLL = 2'b10,
    STY_SEGMENTED = 2'b11
  } style_t;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ARMED = 3'b001,
    ST_PAUSE = 3'b010,
    ST_HELD = 3'b011,
    ST_HALTED = 3'b100
  } state_t;
endpackage

// >>> hdl/acq_arm_control.sv
// Acquisition re-arm, halt, delay, scale and record-length control
// Operation
// - Halt ends current acquisition and blocks new ones in every policy.
// - Halt during single shot keeps the last completed record.
// - Halt during interleaved sampling builds a partial reconstruction.
// - Halt in scroll presents incomplete data as if triggered.
// - Halt in segmented stops timebase and presents new segments.
// - Free-run shows untriggered signal after 500 ms without trigger.
// - Free-run interleaved presents the acquisition every second regardless.
// - Free-run scroll samples continuously with no trigger until halted.
// - Free-run segmented ends on trigger-gap timeout, restarts at segment one.
// - Repeat refreshes on triggers, otherwise keeps record and warns.
// - Repeat interleaved ends once all segments are collected.
// - Repeat scroll ends after post-trigger data, pauses, resumes scrolling.
// - Repeat segmented restarts after last segment; wrap acts as single.
// - Single waits one trigger then stops; second arm forces display.
// - Single interleaved collects all needed events, at most 4000.
// - Single scroll presents without needing a second arm.
// - Pre-trigger delay 0 to 100 percent in 1 percent steps.
// - Post-trigger delay 0 to 10000 divisions in 0.1 steps.
// - Delay-clear sets delay to zero.
// - Horizontal scale steps in a 1-2-5 sequence.
// - Circular segments capture until halt or free-run gap timeout; free-run ignores wrap and presents at the last segment.
// - 1M record only with single shot; interleaved refuses it.
// - Single segmented fills all segments then stops, else waits forever.
//
// The address map and the APB slave port were left to the implementer.
module acq_arm_control
  import acq_arm_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic srst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Trigger circuitry (asynchronous)
  input wire logic trigIn,
  input wire logic segDone,
  input wire logic recDone,
  // Acquisition control outputs
  output logic acqRun,
  output logic presentPulse,
  output logic partialRebuild,
  output logic keepRecord,
  output logic slowTrigWarn,
  output logic [15:0] segIndex
);
  `include "acq_arm_defs.svh"

  // ----------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------
  logic [2:0] syncA_q, syncB_q;
  logic trigPrev_q, segPrev_q, recPrev_q;
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      syncA_q <= 3'b000;
      syncB_q <= 3'b000;
    end else begin
      syncA_q <= {recDone, segDone, trigIn};
      syncB_q <= syncA_q;
    end
  end
  // Edge memories read only the second stage
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      trigPrev_q <= 1'b0;
      segPrev_q <= 1'b0;
      recPrev_q <= 1'b0;
    end else begin
      trigPrev_q <= syncB_q[0];
      segPrev_q <= syncB_q[1];
      recPrev_q <= syncB_q[2];
    end
  end
  logic trigEv, segEv, recEv;
  assign trigEv = syncB_q[0] & ~trigPrev_q;
  assign segEv = syncB_q[1] & ~segPrev_q;
  assign recEv = syncB_q[2] & ~recPrev_q;

  // ----------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------
  logic wrEn, rdEn, mapped;
  assign wrEn = psel & penable & pwrite;
  assign rdEn = psel & penable & ~pwrite;
  assign mapped = (paddr == `ARM_CTRL_OFS) || (paddr == `ARM_DELAY_OFS)
      || (paddr == `ARM_SCALE_OFS) || (paddr == `ARM_SEQ_OFS)
      || (paddr == `ARM_STAT_OFS) || (paddr == `ARM_CMD_OFS);
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~mapped;

  logic cmdWr, armCmd, haltCmd, zeroCmd, scUp, scDn;
  assign cmdWr = wrEn && paddr == `ARM_CMD_OFS;
  assign armCmd = cmdWr & pwdata[`CMD_ARM_BIT];
  assign haltCmd = cmdWr & pwdata[`CMD_HALT_BIT];
  assign zeroCmd = cmdWr & pwdata[`CMD_ZERO_BIT];
  assign scUp = cmdWr & pwdata[`CMD_SCUP_BIT];
  assign scDn = cmdWr & pwdata[`CMD_SCDN_BIT];

  // ----------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------
  policy_t policy_q;
  style_t style_q;
  logic wrap_q;
  logic [2:0] recLen_q;
  // Reclen 4 is the 1M setting; refused outside single shot
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      policy_q <= POL_FREE;
      style_q <= STY_SHOT;
      wrap_q <= 1'b0;
      recLen_q <= 3'd0;
    end else if (wrEn && paddr == `ARM_CTRL_OFS) begin
      if (pwdata[`CTRL_POLICY_LSB +: 2] != 2'b11) begin
        policy_q <= policy_t'(pwdata[`CTRL_POLICY_LSB +: 2]);
      end
      style_q <= style_t'(pwdata[`CTRL_STYLE_LSB +: 2]);
      wrap_q <= pwdata[`CTRL_WRAP_BIT];
      if (pwdata[`CTRL_RECLEN_LSB +: 3] < `RECLEN_MAX) begin
        recLen_q <= pwdata[`CTRL_RECLEN_LSB +: 3];
      end else if (pwdata[`CTRL_RECLEN_LSB +: 3] == `RECLEN_MAX
          && pwdata[`CTRL_STYLE_LSB +: 2] == STY_SHOT) begin
        recLen_q <= `RECLEN_MAX;
      end
    end else if (style_q != STY_SHOT && recLen_q == `RECLEN_MAX) begin
      recLen_q <= `RECLEN_MAX - 3'd1;
    end
  end

  // Delay: bit 31 selects post-trigger, low bits the amount
  logic postMode_q;
  logic [16:0] delayVal_q;
  always_ff @(posedge ref_clk) begin
    if (srst || zeroCmd) begin
      postMode_q <= 1'b0;
      delayVal_q <= 17'd0;
    end else if (wrEn && paddr == `ARM_DELAY_OFS) begin
      postMode_q <= pwdata[`DELAY_POST_BIT];
      if (pwdata[`DELAY_POST_BIT]) begin
        delayVal_q <= (pwdata[16:0] > `POST_MAX_TENTHS) ? `POST_MAX_TENTHS
            : pwdata[16:0];
      end else begin
        delayVal_q <= (pwdata[16:0] > 17'(`PRE_MAX_PCT)) ? 17'(`PRE_MAX_PCT)
            : pwdata[16:0];
      end
    end
  end

  // Scale index: mantissa is index mod 3 mapped to 1, 2, 5
  logic [4:0] scale_q;
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      scale_q <= `SCALE_RESET;
    end else if (scUp && scale_q < `SCALE_MAX) begin
      scale_q <= scale_q + 5'd1;
    end else if (scDn && scale_q != 5'd0) begin
      scale_q <= scale_q - 5'd1;
    end else if (wrEn && paddr == `ARM_SCALE_OFS) begin
      scale_q <= (pwdata[4:0] > `SCALE_MAX) ? `SCALE_MAX : pwdata[4:0];
    end
  end
  logic [3:0] mantissa;
  logic [3:0] decade;
  always_comb begin
    mantissa = 4'd1;
    decade = 4'(scale_q / 5'd3);
    case (scale_q % 5'd3)
      5'd0: mantissa = 4'd1;
      5'd1: mantissa = 4'd2;
      5'd2: mantissa = 4'd5;
      default: mantissa = 4'd1;
    endcase
  end

  // Segment count and segmented-sequence gap timeout
  logic [15:0] segCount_q;
  logic [31:0] seqTmo_q;
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      segCount_q <= 16'h0001;
      seqTmo_q <= `SEQ_TMO_RESET;
    end else if (wrEn && paddr == `ARM_SEQ_OFS) begin
      segCount_q <= (pwdata[15:0] == 16'h0000) ? 16'h0001 : pwdata[15:0];
      seqTmo_q <= {16'h0000, pwdata[31:16]} * 32'd25000;
    end
  end

  // ----------------------------------------------------------
  // Timeout counter, cleared by each trigger except in interleaved style
  // ----------------------------------------------------------
  state_t state_q;
  logic [31:0] gapCnt_q;
  logic [31:0] gapLimit;
  logic gapExpire;
  always_comb begin
    gapLimit = 32'(`FREE_TMO_CYC);
    if (style_q == STY_INTERLEAVED) begin
      gapLimit = 32'(`INTERLEAVE_TMO_CYC);
    end else if (style_q == STY_SEGMENTED) begin
      gapLimit = seqTmo_q;
    end
  end
  assign gapExpire = (state_q == ST_ARMED) && (policy_q == POL_FREE)
      && (gapCnt_q >= gapLimit);
  always_ff @(posedge ref_clk) begin
    if (srst || state_q != ST_ARMED || gapExpire) begin
      gapCnt_q <= 32'd0;
    end else if (trigEv && style_q != STY_INTERLEAVED) begin
      gapCnt_q <= 32'd0;
    end else begin
      gapCnt_q <= gapCnt_q + 32'd1;
    end
  end

  // Scroll pause timer for repeat policy
  logic [23:0] pauseCnt_q;
  always_ff @(posedge ref_clk) begin
    if (srst || state_q != ST_PAUSE) begin
      pauseCnt_q <= 24'd0;
    end else begin
      pauseCnt_q <= pauseCnt_q + 24'd1;
    end
  end

  // ----------------------------------------------------------
  // Arm state machine
  // ----------------------------------------------------------
  logic [11:0] events_q;
  logic [15:0] seg_q;
  logic present, partial, needLimit;
  logic lastSeg;
  assign lastSeg = (seg_q + 16'd1 >= segCount_q);
  assign needLimit = (events_q >= `INTERLEAVE_MAX - 12'd1);
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      state_q <= ST_IDLE;
    end else if (haltCmd) begin
      state_q <= ST_HALTED;
    end else begin
      case (state_q)
        ST_IDLE, ST_HALTED: begin
          if (armCmd) begin
            state_q <= ST_ARMED;
          end
        end
        ST_ARMED: begin
          if (policy_q == POL_SINGLE) begin
            if (armCmd && style_q == STY_SHOT) begin
              state_q <= ST_HELD;
            end else if (style_q == STY_INTERLEAVED) begin
              if (recEv || (trigEv && needLimit)) state_q <= ST_HELD;
            end else if (style_q == STY_SEGMENTED) begin
              if (segEv && lastSeg && !wrap_q) state_q <= ST_HELD;
            end else if (recEv) begin
              state_q <= ST_HELD;
            end
          end else if (style_q == STY_SCROLL && policy_q == POL_REPEAT && recEv) begin
            state_q <= ST_PAUSE;
          end
        end
        ST_PAUSE: begin
          if (pauseCnt_q >= 24'(`PAUSE_CYC - 1)) state_q <= ST_ARMED;
        end
        ST_HELD: begin
          if (armCmd) state_q <= ST_ARMED;
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // Segment index and interleaved event count
  always_ff @(posedge ref_clk) begin
    if (srst || state_q != ST_ARMED) begin
      seg_q <= 16'd0;
    end else if (gapExpire && style_q == STY_SEGMENTED) begin
      seg_q <= 16'd0;
    end else if (segEv && style_q == STY_SEGMENTED) begin
      seg_q <= lastSeg ? 16'd0 : seg_q + 16'd1;
    end
  end
  always_ff @(posedge ref_clk) begin
    if (srst || state_q != ST_ARMED || recEv || present) begin
      events_q <= 12'd0;
    end else if (trigEv && style_q == STY_INTERLEAVED && !needLimit) begin
      events_q <= events_q + 12'd1;
    end
  end

  // Present decision for each policy and style
  always_comb begin
    present = 1'b0;
    partial = 1'b0;
    if (state_q == ST_ARMED && !haltCmd) begin
      case (style_q)
        STY_INTERLEAVED: begin
          present = recEv;
          if (policy_q == POL_SINGLE && trigEv && needLimit) present = 1'b1;
          if (policy_q == POL_FREE && gapExpire) begin
            present = 1'b1;
            partial = 1'b1;
          end
        end
        STY_SCROLL: present = (policy_q != POL_FREE) && recEv;
        STY_SEGMENTED: begin
          present = segEv && lastSeg && !(wrap_q && policy_q != POL_FREE);
          if (gapExpire) present = 1'b1;
        end
        default: begin
          present = recEv;
          if (gapExpire) present = 1'b1;
        end
      endcase
      if (policy_q == POL_SINGLE && style_q == STY_SHOT && armCmd) begin
        present = 1'b1;
      end
    end else if (haltCmd && state_q == ST_ARMED) begin
      present = (style_q != STY_SHOT);
      partial = (style_q == STY_INTERLEAVED);
    end
  end

  // Outputs
  logic warn_q;
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      presentPulse <= 1'b0;
      partialRebuild <= 1'b0;
      warn_q <= 1'b0;
    end else begin
      presentPulse <= present;
      partialRebuild <= partial;
      if (present || state_q != ST_ARMED || policy_q != POL_REPEAT) begin
        warn_q <= 1'b0;
      end else if (gapCnt_q >= 32'(`FREE_TMO_CYC)) begin
        warn_q <= 1'b1;
      end
    end
  end
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      acqRun <= 1'b0;
      keepRecord <= 1'b0;
      segIndex <= 16'd0;
    end else begin
      acqRun <= (state_q == ST_ARMED) && !haltCmd;
      keepRecord <= (state_q != ST_ARMED) || haltCmd;
      segIndex <= seg_q;
    end
  end
  assign slowTrigWarn = warn_q;

  // ----------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      case (paddr)
        `ARM_CTRL_OFS: prdata <= {21'd0, recLen_q, 3'd0, wrap_q, style_q, policy_q};
        `ARM_DELAY_OFS: prdata <= {postMode_q, 14'd0, delayVal_q};
        `ARM_SCALE_OFS: prdata <= {16'd0, mantissa, decade, 3'd0, scale_q};
        `ARM_SEQ_OFS: prdata <= {16'd0, segCount_q};
        `ARM_STAT_OFS: prdata <= {seg_q, events_q, warn_q, state_q};
        default: prdata <= 32'h0000_0000;
      endcase
    end
  end
endmodule

// >>> tb/acq_arm_chk.sv
// Port checker for the acquisition arm controller
`include "acq_arm_defs.svh"
module acq_arm_chk (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic srst,
  // APB
  input wire logic psel, penable, pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata, prdata,
  input wire logic pready, pslverr,
  // Events and outputs
  input wire logic trigIn, segDone, recDone,
  input wire logic acqRun, presentPulse, partialRebuild,
  input wire logic keepRecord, slowTrigWarn,
  input wire logic [15:0] segIndex
);
  logic acc;
  logic mapped;
  logic [1:0] pol_q;
  logic [1:0] sty_q;
  logic halt_q;
  assign acc = psel && penable;
  assign mapped = paddr <= `ARM_CMD_OFS && paddr[1:0] == 2'b00;
  // Shadow of policy, style and halt, so stop checks know the mode
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      pol_q <= 2'd0;
      sty_q <= 2'd0;
      halt_q <= 1'b0;
    end else if (acc && pwrite) begin
      if (paddr == `ARM_CTRL_OFS && pwdata[1:0] != 2'd3) pol_q <= pwdata[1:0];
      if (paddr == `ARM_CTRL_OFS) sty_q <= pwdata[3:2];
      if (paddr == `ARM_CMD_OFS && pwdata[1]) halt_q <= 1'b1;
      else if (paddr == `ARM_CMD_OFS && pwdata[0]) halt_q <= 1'b0;
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);
  sequence haltWr;
    acc && pwrite && paddr == `ARM_CMD_OFS && pwdata[`CMD_HALT_BIT];
  endsequence
  a_ready_high: assert property (acc |-> pready)
    else $error("pready low in access");
  a_err_unmapped: assert property (acc && !mapped |-> pslverr)
    else $error("no error on unmapped access");
  a_err_mapped: assert property (acc && mapped |-> !pslverr)
    else $error("error on mapped access");
  a_halt_stops: assert property (haltWr |-> ##[1:2] !acqRun)
    else $error("run kept after halt");
  a_halt_blocks: assert property (halt_q && $past(halt_q) |-> !acqRun)
    else $error("run restarted while halted");
  a_halt_keeps: assert property (haltWr ##0 sty_q == 2'd0 |-> ##[1:2] keepRecord)
    else $error("record dropped on halt");
  a_halt_partial: assert property (haltWr ##0 (acqRun && sty_q == 2'd1)
    |-> ##[1:4] (presentPulse && partialRebuild))
    else $error("no partial rebuild on halt");
  a_partial_with: assert property (partialRebuild |-> presentPulse)
    else $error("rebuild without present");
  a_pulse_once: assert property (presentPulse |=> !presentPulse)
    else $error("present longer than one cycle");
  a_single_stop: assert property (presentPulse && pol_q == 2'd2 && sty_q == 2'd0
    |=> !acqRun)
    else $error("single run kept after present");
  a_reset_state: assert property (disable iff (1'b0) srst |=> !acqRun && !presentPulse
    && !keepRecord && segIndex == 16'h0000)
    else $error("bad state after reset");
  a_idle_keeps: assert property (disable iff (1'b0) srst ##1 !srst |=> keepRecord)
    else $error("record not held when idle after reset");
endmodule
bind acq_arm_control acq_arm_chk chk (.ref_clk(ref_clk), .srst(srst), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .trigIn(trigIn), .segDone(segDone),
  .recDone(recDone), .acqRun(acqRun), .presentPulse(presentPulse),
  .partialRebuild(partialRebuild), .keepRecord(keepRecord),
  .slowTrigWarn(slowTrigWarn), .segIndex(segIndex));

// >>> tb/trig_src.sv
// Trigger circuitry model driving the event lines
module trig_src (
  // Clock, reset and requests
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic [2:0] fire,
  // Event lines
  output logic trigIn,
  output logic segDone,
  output logic recDone
);
  logic [2:0] lvl_q;
  logic [2:0][2:0] cnt_q;
  assign {recDone, segDone, trigIn} = lvl_q;
  // Each event held 4 cycles so the synchroniser sees one clean edge
  always_ff @(posedge ref_clk) begin
    for (int i = 0; i < 3; i++) begin
      if (srst) begin
        lvl_q[i] <= 1'b0;
        cnt_q[i] <= 3'd0;
      end else if (fire[i]) begin
        lvl_q[i] <= 1'b1;
        cnt_q[i] <= 3'd4;
      end else if (cnt_q[i] != 3'd0) begin
        cnt_q[i] <= cnt_q[i] - 3'd1;
        lvl_q[i] <= cnt_q[i] != 3'd1;
      end
    end
  end
endmodule

// >>> tb/testbench.sv
// Self-checking bench of the acquisition arm controller
`include "acq_arm_defs.svh"
module testbench;
  import acq_arm_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct {logic [11:0] a; logic [31:0] d; logic [31:0] x; logic e;} row_t;
  logic ref_clk, srst, psel, penable, pwrite, pready, pslverr, err, partSeen;
  logic trigIn, segDone, recDone, acqRun, presentPulse, partialRebuild;
  logic keepRecord, slowTrigWarn;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, ex;
  logic [15:0] segIndex;
  logic [2:0] fire;
  logic [3:0] m3 [3];
  row_t rows [7];
  int nFail, testsRun, cyc, presCnt, base, idx;
  acq_arm_control DUT (.ref_clk(ref_clk), .srst(srst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .trigIn(trigIn), .segDone(segDone), .recDone(recDone),
    .acqRun(acqRun), .presentPulse(presentPulse), .partialRebuild(partialRebuild),
    .keepRecord(keepRecord), .slowTrigWarn(slowTrigWarn), .segIndex(segIndex));
  trig_src src (.ref_clk(ref_clk), .srst(srst), .fire(fire), .trigIn(trigIn),
    .segDone(segDone), .recDone(recDone));
  // ----------------
  // Tasks
  // ----------------
  task automatic final_report();
    if (nFail == 0 && testsRun > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    testsRun++;
    if (got !== exp) begin
      nFail++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // One APB transfer; released a cycle later so strobes never re-arm in one step
  task automatic apb(input logic [11:0] a, input logic [31:0] d, input logic w);
    psel <= 1'b1;
    paddr <= a;
    pwdata <= d;
    pwrite <= w;
    @(posedge ref_clk);
    penable <= 1'b1;
    @(posedge ref_clk);
    while (pready !== 1'b1) @(posedge ref_clk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic ev(input int i);
    fire <= 3'(1 << i);
    @(posedge ref_clk);
    fire <= 3'b000;
    repeat (10) @(posedge ref_clk);
  endtask
  task automatic arm(input logic [31:0] c);
    apb(`ARM_CTRL_OFS, c, 1'b1);
    apb(`ARM_CMD_OFS, 32'h0000_0001, 1'b1);
    repeat (2) @(posedge ref_clk);
    base = presCnt;
  endtask
  // Present pulses counted here, as they may land inside a bus transfer
  always @(posedge ref_clk) begin
    cyc++;
    if (presentPulse === 1'b1) begin
      presCnt++;
      partSeen = partialRebuild;
    end
    if (cyc == 40000) begin
      nFail++;
      final_report();
    end
  end
  always #20 ref_clk = ~ref_clk;
  initial begin
    ref_clk = 0;
    srst = 1;
    {psel, penable, pwrite, paddr, pwdata, fire} = '0;
    m3 = '{4'd1, 4'd2, 4'd5};
    rows = '{'{`ARM_CTRL_OFS, 32'h0000_0012, 32'h0000_0012, 0},
      '{`ARM_CTRL_OFS, 32'h0000_0403, 32'h0000_0402, 0},
      '{`ARM_CTRL_OFS, 32'h0000_0405, 32'h0000_0305, 0},
      '{`ARM_DELAY_OFS, 32'h0000_00C8, 32'h0000_0064, 0},
      '{`ARM_DELAY_OFS, 32'h8001_FFFF, 32'h8001_86A0, 0},
      '{`ARM_SEQ_OFS, 32'h0064_0004, 32'h0000_0004, 0},
      '{12'h020, 32'h0000_0000, 32'h0000_0000, 1}};
    repeat (5) @(posedge ref_clk);
    srst <= 0;
    @(posedge ref_clk);
    for (int i = 0; i < 7; i++) begin
      apb(rows[i].a, rows[i].d, 1'b1);
      chk("pslverr", err, rows[i].e);
      apb(rows[i].a, 32'h0000_0000, 1'b0);
      if (!rows[i].e) chk("readback", rd, rows[i].x);
    end
    apb(`ARM_CMD_OFS, 32'h0000_0004, 1'b1);
    apb(`ARM_DELAY_OFS, 32'h0000_0000, 1'b0);
    chk("delay", rd[16:0], 0);
    for (int i = 0; i < 19; i++) begin
      apb(`ARM_CMD_OFS, 32'h0000_0008, 1'b1);
      apb(`ARM_SCALE_OFS, 32'h0000_0000, 1'b0);
      idx = (10 + i > 26) ? 26 : 10 + i;
      ex = {16'h0000, m3[idx % 3], 4'(idx / 3), 3'b000, 5'(idx)};
      chk("scale", rd & 32'h0000_FF1F, ex);
    end
    arm(32'h0000_0002);
    chk("acqRun", acqRun, 1);
    ev(0);
    ev(2);
    chk("present", 32'(presCnt - base), 1);
    chk("acqRun", acqRun, 0);
    arm(32'h0000_0002);
    apb(`ARM_CMD_OFS, 32'h0000_0001, 1'b1);
    repeat (10) @(posedge ref_clk);
    chk("present", 32'(presCnt - base), 1);
    chk("acqRun", acqRun, 0);
    arm(32'h0000_0001);
    apb(`ARM_CMD_OFS, 32'h0000_0002, 1'b1);
    apb(`ARM_STAT_OFS, 32'h0000_0000, 1'b0);
    chk("state", rd[2:0], 4);
    chk("keepRecord", keepRecord, 1);
    base = presCnt;
    ev(0);
    chk("present", 32'(presCnt - base), 0);
    chk("acqRun", acqRun, 0);
    arm(32'h0000_0006);
    ev(0);
    apb(`ARM_CMD_OFS, 32'h0000_0002, 1'b1);
    repeat (10) @(posedge ref_clk);
    chk("present", 32'(presCnt - base), 1);
    chk("partial", partSeen, 1);
    apb(`ARM_SEQ_OFS, 32'h03E8_0003, 1'b1);
    arm(32'h0000_000E);
    ev(1);
    ev(1);
    chk("present", 32'(presCnt - base), 0);
    chk("acqRun", acqRun, 1);
    ev(1);
    chk("present", 32'(presCnt - base), 1);
    chk("acqRun", acqRun, 0);
    arm(32'h0000_000A);
    ev(2);
    chk("present", 32'(presCnt - base), 1);
    chk("acqRun", acqRun, 0);
    // Free-run segmented with a 1 ms gap limit, then halt
    apb(`ARM_SEQ_OFS, 32'h0001_0003, 1'b1);
    arm(32'h0000_000C);
    ev(1);
    chk("segIndex", segIndex, 1);
    repeat (25000) @(posedge ref_clk);
    chk("present", 32'(presCnt - base), 1);
    chk("segIndex", segIndex, 0);
    apb(`ARM_CMD_OFS, 32'h0000_0002, 1'b1);
    repeat (3) @(posedge ref_clk);
    chk("present", 32'(presCnt - base), 2);
    srst <= 1;
    repeat (2) @(posedge ref_clk);
    srst <= 0;
    repeat (2) @(posedge ref_clk);
    chk("outs", {acqRun, presentPulse, slowTrigWarn, keepRecord, segIndex}, 32'h1_0000);
    apb(`ARM_SCALE_OFS, 32'h0000_0000, 1'b0);
    chk("scale", rd[4:0], 9);
    apb(`ARM_CTRL_OFS, 32'h0000_0000, 1'b0);
    chk("ctrl", rd, 0);
    final_report();
  end
endmodule
